// ===== design/emi_irq_flags.sv
// emi_irq_flags.sv: energy measurement status flags, enables and pending interrupt.
// assumes: core reaches registers by a one-cycle read/write strobe on its own clock;
// event inputs are one-cycle pulses from engine logic on the same clock.
//
// Summary of operation
// - pulse output b event sets mid bit 7
// - pulse output a event sets mid bit 6
// - energy overflows set mid bits 5 to 3
// - energy half full sets mid bits 2 to 0
// - reset completion sets high bit 7
// - new waveform sample sets high bit 5
// - peak exceeded sets high bits 4, 3
// - line cycle accumulation done sets high bit 2
// - zero crossing timeout sets high bit 1
// - zero crossing detected sets high bit 0
// - low enable bits 4..0, upper reserved
// - mid enables 7, 6 gate pulse events
// - mid enables 5..0 gate overflow, half full
// - high enables 5..0 gate, upper reserved
// - gain register holds current and voltage selects
// - aggregate low bit 7 follows enabled flags
// - gain codes 000 to 100 mean 1..16
// - low status holds sign and no-load flags
// - waveform interrupt holds until flag cleared
`timescale 1ns/1ps
`include "emi_params.svh"

module emi_irq_flags (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // engine events, one-cycle pulses
  input  wire emi_pkg::emi_events_type i_events,
  // register access
  input  wire emi_pkg::emi_sfr_req_type i_sfr,
  output logic                  [7:0] o_rdata,
  // to the core and the analog stage
  output logic                        o_irq_pending,
  output logic                  [2:0] o_current_gain_select,
  output logic                  [2:0] o_voltage_gain_select,
  output logic                  [4:0] o_current_gain,
  output logic                  [4:0] o_voltage_gain
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    emi_pkg::emi_phase_type phase;
    logic [7:0] st_low;
    logic [7:0] st_mid;
    logic [7:0] st_high;
    logic [7:0] en_low;
    logic [7:0] en_mid;
    logic [7:0] en_high;
    logic [7:0] gain;
    logic [7:0] rdata;
    logic       irq;
  } emi_state_type;

  emi_state_type st_r;
  emi_state_type st_nxt;

  // software writes a 0 to a flag bit to clear it; set from hardware wins
  function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] set,
                                             input logic clr_wr, input logic [7:0] wdata,
                                             input logic [7:0] mask);
    logic [7:0] kept;
    kept = clr_wr ? (cur & wdata) : cur;
    flag_update = (kept | set) & mask;
  endfunction

  function automatic logic any_enabled(input logic [7:0] flags, input logic [7:0] en);
    any_enabled = |(flags & en);
  endfunction

  logic       wr_low;
  logic       wr_mid;
  logic       wr_high;
  logic [7:0] set_low;
  logic [7:0] set_mid;
  logic [7:0] set_high;
  logic       reset_done;
  logic       pending;
  logic [7:0] rd_mux;

  // ----------------------------------------
  // decode and next state
  // ----------------------------------------
  always_comb begin
    st_nxt     = st_r;
    wr_low     = 1'b0;
    wr_mid     = 1'b0;
    wr_high    = 1'b0;
    reset_done = 1'b0;
    rd_mux     = `EMI_ZERO8;
    if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_STATUS_LOW) begin
      wr_low = 1'b1;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_STATUS_MID) begin
      wr_mid = 1'b1;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_STATUS_HIGH) begin
      wr_high = 1'b1;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_ENABLE_LOW) begin
      st_nxt.en_low = i_sfr.wdata & `EMI_MASK_LOW;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_ENABLE_MID) begin
      st_nxt.en_mid = i_sfr.wdata & `EMI_MASK_MID;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_ENABLE_HIGH) begin
      st_nxt.en_high = i_sfr.wdata & `EMI_MASK_EN_HIGH;
    end else if (i_sfr.wr && i_sfr.addr == `EMI_ADDR_GAIN) begin
      st_nxt.gain = i_sfr.wdata & `EMI_MASK_GAIN;
    end

    case (st_r.phase)
      emi_pkg::EMI_ST_RESET: begin
        reset_done   = 1'b1;
        st_nxt.phase = emi_pkg::EMI_ST_RUN;
      end
      emi_pkg::EMI_ST_RUN: begin
        st_nxt.phase = emi_pkg::EMI_ST_RUN;
      end
      default: begin
        st_nxt.phase = emi_pkg::EMI_ST_RESET;
      end
    endcase

    set_low  = {3'h0, i_events.low};
    set_mid  = i_events.mid;
    set_high = i_events.high;
    set_high[`EMI_RESET_FLAG_BIT] = i_events.high[`EMI_RESET_FLAG_BIT] | reset_done;

    // aggregate bit of the low register is computed, never stored from writes
    st_nxt.st_low  = flag_update(st_r.st_low, set_low, wr_low, i_sfr.wdata,
                                 `EMI_MASK_LOW);
    st_nxt.st_mid  = flag_update(st_r.st_mid, set_mid, wr_mid, i_sfr.wdata,
                                 `EMI_MASK_MID);
    st_nxt.st_high = flag_update(st_r.st_high, set_high, wr_high, i_sfr.wdata,
                                 `EMI_MASK_HIGH);

    pending = any_enabled(st_nxt.st_low, st_nxt.en_low)
            | any_enabled(st_nxt.st_mid, st_nxt.en_mid)
            | any_enabled(st_nxt.st_high, st_nxt.en_high);
    st_nxt.irq = pending;
    st_nxt.st_low[`EMI_AGG_BIT] = pending;

    if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_STATUS_LOW) begin
      rd_mux = st_r.st_low;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_STATUS_MID) begin
      rd_mux = st_r.st_mid;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_STATUS_HIGH) begin
      rd_mux = st_r.st_high;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_ENABLE_LOW) begin
      rd_mux = st_r.en_low;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_ENABLE_MID) begin
      rd_mux = st_r.en_mid;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_ENABLE_HIGH) begin
      rd_mux = st_r.en_high;
    end else if (i_sfr.rd && i_sfr.addr == `EMI_ADDR_GAIN) begin
      rd_mux = st_r.gain;
    end
    st_nxt.rdata = rd_mux;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r       <= '0;
      st_r.phase <= emi_pkg::EMI_ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata               = st_r.rdata;
  assign o_irq_pending         = st_r.irq;
  assign o_current_gain_select = st_r.gain[2:0];
  assign o_voltage_gain_select = st_r.gain[7:5];

  emi_gain_decode u_cur_gain (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_code (st_nxt.gain[2:0]),
    .o_gain (o_current_gain)
  );

  emi_gain_decode u_volt_gain (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_code (st_nxt.gain[7:5]),
    .o_gain (o_voltage_gain)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_pulse_b_sets: assert property (i_events.mid[7] |=> st_r.st_mid[7])
    else $error("pulse b event did not set flag");
  chk_pulse_a_sets: assert property (i_events.mid[6] |=> st_r.st_mid[6])
    else $error("pulse a event did not set flag");
  chk_overflow_sets: assert property (|i_events.mid[5:3] |=>
                                      ((st_r.st_mid[5:3] & $past(i_events.mid[5:3]))
                                       == $past(i_events.mid[5:3])))
    else $error("overflow event lost");
  chk_half_full_sets: assert property (|i_events.mid[2:0] |=>
                                       ((st_r.st_mid[2:0] & $past(i_events.mid[2:0]))
                                        == $past(i_events.mid[2:0])))
    else $error("half full event lost");
  chk_reset_end_flag: assert property ($rose(st_r.phase == emi_pkg::EMI_ST_RUN)
                                       |-> st_r.st_high[7])
    else $error("reset end flag missing");
  chk_wave_sets: assert property (i_events.high[5] |=> st_r.st_high[5])
    else $error("waveform flag not set");
  chk_peak_sets: assert property (|i_events.high[4:3] |=>
                                  ((st_r.st_high[4:3] & $past(i_events.high[4:3]))
                                   == $past(i_events.high[4:3])))
    else $error("peak flag not set");
  chk_cycle_sets: assert property (i_events.high[2] |=> st_r.st_high[2])
    else $error("cycle end flag not set");
  chk_timeout_sets: assert property (i_events.high[1] |=> st_r.st_high[1])
    else $error("timeout flag not set");
  chk_zx_sets: assert property (i_events.high[0] |=> st_r.st_high[0])
    else $error("zero crossing flag not set");
  chk_reserved_zero: assert property (
                                      st_r.en_low[7:5] == 3'h0 && st_r.en_high[7:6] == 2'h0
                                      && st_r.st_high[6] == 1'b0)
    else $error("reserved bit set");
  chk_irq_or: assert property (
                               o_irq_pending == (|(st_r.st_low[4:0] & st_r.en_low[4:0])
                               || |(st_r.st_mid & st_r.en_mid)
                               || |(st_r.st_high & st_r.en_high)))
    else $error("pending request mismatch");
  chk_aggregate: assert property (st_r.st_low[7] == o_irq_pending)
    else $error("aggregate bit mismatch");
  chk_wave_holds: assert property (st_r.st_high[5] && st_r.en_high[5] && !i_sfr.wr
                                   |=> o_irq_pending)
    else $error("waveform interrupt dropped");
  chk_set_wins: assert property (i_events.mid[6] && i_sfr.wr
                                 && i_sfr.addr == `EMI_ADDR_STATUS_MID
                                 |=> st_r.st_mid[6])
    else $error("set lost against clear");
  // decode and select load at the same edge, so they are compared in one cycle
  chk_gain_code: assert property (st_r.gain[2:0] <= `EMI_GAIN_MAX
                                  |-> o_current_gain == (5'h01 << st_r.gain[2:0]))
    else $error("current gain decode wrong");
  chk_vgain_code: assert property (st_r.gain[7:5] <= `EMI_GAIN_MAX
                                   |-> o_voltage_gain == (5'h01 << st_r.gain[7:5]))
    else $error("voltage gain decode wrong");

  cov_irq_rise: cover property ($rose(o_irq_pending));
  cov_set_clear: cover property (i_events.high[0] && wr_high);
  cov_clear_drop: cover property (o_irq_pending ##1 !o_irq_pending);
  cov_gain16: cover property (o_voltage_gain == 5'h10);

endmodule // emi_irq_flags

// ===== design/emi_params.svh
// emi_params.svh: offsets, field positions and reset values of the energy interrupt block.
// assumes: included by design files by bare name; defines only.
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH

// ----------------------------------------
// register addresses (8-bit special function register space)
// ----------------------------------------
`define EMI_ADDR_ENABLE_LOW   8'hD9
`define EMI_ADDR_ENABLE_MID   8'hDA
`define EMI_ADDR_ENABLE_HIGH  8'hDB
`define EMI_ADDR_STATUS_LOW   8'hDC
`define EMI_ADDR_STATUS_MID   8'hDD
`define EMI_ADDR_STATUS_HIGH  8'hDE
`define EMI_ADDR_GAIN         8'h1B

// ----------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------
`define EMI_MASK_LOW          8'h1F
`define EMI_MASK_MID          8'hFF
`define EMI_MASK_HIGH         8'hBF
`define EMI_MASK_EN_HIGH      8'h3F
`define EMI_MASK_GAIN         8'hE7
`define EMI_RESET_REG         8'h00
`define EMI_RESET_FLAG_BIT    7
`define EMI_AGG_BIT           7
`define EMI_GAIN_MAX          3'h4
// decoded gain of select code 000, the select field's reset value
`define EMI_GAIN_RESET        5'h01
`define EMI_ZERO8             8'h00

`endif

// ===== design/emi_pkg.sv
// emi_pkg.sv: types shared by the energy interrupt block.
// assumes: constants come from emi_params.svh.
package emi_pkg;

  // one-cycle event pulses from the measurement engine
  typedef struct packed {
    logic [4:0] low;   // sign change and no-load events
    logic [7:0] mid;   // pulse outputs, overflow, half full
    logic [7:0] high;  // reset end, waveform, peaks, cycle end, timeout, zero crossing
  } emi_events_type;

  // register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } emi_sfr_req_type;

  typedef enum logic [1:0] {
    EMI_ST_RESET = 2'b01,
    EMI_ST_RUN   = 2'b10
  } emi_phase_type;

endpackage

// ===== design/emi_gain_decode.sv
// emi_gain_decode.sv: turns a three-bit gain select code into a gain factor.
// assumes: same clock as the parent; register output.
`timescale 1ns/1ps
`include "emi_params.svh"

module emi_gain_decode (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // select code
  input  wire logic [2:0] i_code,
  // decoded gain, 1 to 16; 0 marks an unused code
  output logic      [4:0] o_gain
);

  typedef struct packed {
    logic [4:0] gain;
  } emi_gain_state_type;

  emi_gain_state_type st_r;
  emi_gain_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_code <= `EMI_GAIN_MAX) begin
      st_nxt.gain = 5'h01 << i_code;
    end else begin
      st_nxt.gain = 5'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // follows the select field's reset code, so gain and select never disagree
      st_r <= '{gain: `EMI_GAIN_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_gain = st_r.gain;

endmodule // emi_gain_decode

// ===== verif/emi_core_model.sv
// emi_core_model.sv: processor core side, issuing register reads and writes.
// assumes: block samples requests on the rising edge; one request per call.
`timescale 1ns/1ps

module emi_core_model (
  // clock
  input  wire logic               i_clk,
  // register requests to the block
  output emi_pkg::emi_sfr_req_type o_sfr
);
  initial o_sfr = '0;

  // ----------------------------------------
  // access task
  // ----------------------------------------
  // released bus shows inverted address and data, so stale values never pass for live ones
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    o_sfr <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(negedge i_clk);
    o_sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask
endmodule // emi_core_model

// ===== verif/emi_irq_flags_tb.sv
// emi_irq_flags_tb.sv: self-checking bench for the energy interrupt flags.
// assumes: emi_core_model drives register requests; bench drives events and reset.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module emi_irq_flags_tb;
  logic                     i_clk;
  logic                     i_rst;
  emi_pkg::emi_events_type  ev;
  emi_pkg::emi_sfr_req_type sfr;
  logic [7:0]               rdata;
  logic                     irq;
  logic [2:0]               csel;
  logic [2:0]               vsel;
  logic [4:0]               cgain;
  logic [4:0]               vgain;
  logic [7:0]               st [3];
  logic [7:0]               en [3];
  logic [7:0]               exp_q [$];
  logic [7:0]               exp_v;
  logic                     rd_seen;
  int                       error_cnt;
  int                       n_tests;
  int                       seed;
  int                       g;
  int                       b;
  int                       c;
  localparam logic [23:0]   SMASK = 24'hBFFF1F;
  localparam logic [23:0]   EMASK = 24'h3FFF1F;

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  emi_core_model u_emi_core_model (.i_clk(i_clk), .o_sfr(sfr));

  emi_irq_flags u_emi_irq_flags (
    .i_clk(i_clk), .i_rst(i_rst), .i_events(ev), .i_sfr(sfr), .o_rdata(rdata),
    .o_irq_pending(irq), .o_current_gain_select(csel), .o_voltage_gain_select(vsel),
    .o_current_gain(cgain), .o_voltage_gain(vgain));

  // ----------------------------------------
  // read data monitor
  // ----------------------------------------
  always @(posedge i_clk) rd_seen <= sfr.rd;
  always @(negedge i_clk) begin
    if (rd_seen === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic irq_exp();
    return |((st[0] & en[0]) | (st[1] & en[1]) | (st[2] & en[2]));
  endfunction
  function automatic logic [4:0] gexp(input int k);
    return (k < 5) ? (5'h01 << k) : 5'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_emi_core_model.access(1'b1, a, d);
    if (a >= 8'hD9 && a <= 8'hDB) en[a - 8'hD9] = d & EMASK[(a - 8'hD9) * 8 +: 8];
    if (a >= 8'hDC && a <= 8'hDE) st[a - 8'hDC] &= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_emi_core_model.access(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input int gi, input int bi);
    @(negedge i_clk);
    ev <= 21'h000001 << ((gi == 0) ? 16 + bi : (gi == 1) ? 8 + bi : bi);
    @(negedge i_clk);
    ev <= '0;
    st[gi][bi] |= SMASK[gi * 8 + bi];
  endtask
  task automatic chk();
    rd(8'hDC, {irq_exp(), 2'b00, st[0][4:0]});
    rd(8'hDD, st[1]);
    rd(8'hDE, st[2]);
    `CHK(irq, irq_exp())
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 5;
    error_cnt = 0;
    n_tests = 0;
    i_rst = 1'b1;
    ev = '0;
    st = '{8'h00, 8'h00, 8'h80};
    en = '{8'h00, 8'h00, 8'h00};
    repeat (12) @(negedge i_clk);
    i_rst <= 1'b0;
    chk();
    for (g = 0; g < 3; g++) rd(8'(8'hD9 + g), 8'h00);
    wr(8'hDF, 8'hFF);
    rd(8'hDF, 8'h00);
    wr(8'hDE, 8'h00);
    // every event bit, with random enables; coincident clear must lose to the event
    for (g = 0; g < 3; g++) begin
      for (b = 0; b < 8; b++) begin
        if (g == 0 && b > 4) continue;
        wr(8'(8'hD9 + g), 8'($random(seed)));
        pulse(g, b);
        chk();
        fork
          wr(8'(8'hDC + g), ~(8'h01 << b));
          pulse(g, b);
        join
        st[g][b] |= SMASK[g * 8 + b];
        chk();
        wr(8'(8'hDC + g), ~(8'h01 << b));
        chk();
      end
    end
    wr(8'hDB, 8'h20);
    pulse(2, 5);
    repeat (8) @(negedge i_clk);
    `CHK(irq, 1'b1)
    wr(8'hDE, 8'hDF);
    `CHK(irq, irq_exp())
    // all eight codes on both gain fields, reserved bits written high
    for (c = 0; c < 8; c++) begin
      wr(8'h1B, {3'(c), 2'b11, 3'(7 - c)});
      rd(8'h1B, {3'(c), 2'b00, 3'(7 - c)});
      `CHK({vsel, csel}, {3'(c), 3'(7 - c)})
      `CHK({vgain, cgain}, {gexp(c), gexp(7 - c)})
    end
    conclude();
  end

  // roughly 620 cycles expected; generous margin
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    conclude();
  end
endmodule // emi_irq_flags_tb
